// File: pkg/dmaec_pkg.sv
// package: register map, field layout and request carrier for the event capture front end
package dmaec_pkg;

  // channel counts of the two variants
  localparam int NCH = 64;
  localparam int NCH_NARROW = 16;
  localparam int CH_IDX_W = 6;

  // register byte addresses
  localparam logic [31:0] A_POL_HI = 32'h01a0ff9c;
  localparam logic [31:0] A_IRQ_PEND_HI = 32'h01a0ffa4;
  localparam logic [31:0] A_IRQ_EN_HI = 32'h01a0ffa8;
  localparam logic [31:0] A_CHAIN_HI = 32'h01a0ffac;
  localparam logic [31:0] A_PEND_HI = 32'h01a0ffb0;
  localparam logic [31:0] A_EN_HI = 32'h01a0ffb4;
  localparam logic [31:0] A_CLR_HI = 32'h01a0ffb8;
  localparam logic [31:0] A_SET_HI = 32'h01a0ffbc;
  localparam logic [31:0] A_QALLOC_0 = 32'h01a0ffc0;
  localparam logic [31:0] A_QALLOC_1 = 32'h01a0ffc4;
  localparam logic [31:0] A_QALLOC_2 = 32'h01a0ffc8;
  localparam logic [31:0] A_QALLOC_3 = 32'h01a0ffcc;
  localparam logic [31:0] A_POL_LO = 32'h01a0ffdc;
  localparam logic [31:0] A_QSTATE = 32'h01a0ffe0;
  localparam logic [31:0] A_IRQ_PEND_LO = 32'h01a0ffe4;
  localparam logic [31:0] A_IRQ_EN_LO = 32'h01a0ffe8;
  localparam logic [31:0] A_CHAIN_LO = 32'h01a0ffec;
  localparam logic [31:0] A_PEND_LO = 32'h01a0fff0;
  localparam logic [31:0] A_EN_LO = 32'h01a0fff4;
  localparam logic [31:0] A_CLR_LO = 32'h01a0fff8;
  localparam logic [31:0] A_SET_LO = 32'h01a0fffc;
  localparam logic [31:0] A_GEO_CNT = 32'h01a0ff80;
  localparam logic [31:0] A_GEO_IDX = 32'h01a0ff84;

  // geometry register fields
  localparam int GEO_ELEM_LSB = 0;
  localparam int GEO_2D_BIT = 16;
  localparam int GEO_WHOLE_BIT = 17;
  localparam int GEO_ERR_BIT = 31;
  localparam int GEO_FRM_LSB = 0;
  localparam int GEO_STRIDE_LSB = 16;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [63:0] RST_VEC = 64'h0000000000000000;
  localparam logic [15:0] RST_ELEM_CNT = 16'h0001;
  localparam logic [15:0] RST_FIELD = 16'h0000;

  // channel masks
  localparam logic [63:0] MASK_WIDE = 64'hffffffffffffffff;
  localparam logic [63:0] MASK_NARROW = 64'h000000000000ffff;
  localparam logic [63:0] CHAIN_ONLY_NARROW = 64'h0000000000000f00;

  typedef enum logic [1:0] {
    DMAEC_SYNC_ELEMENT,
    DMAEC_SYNC_FRAME,
    DMAEC_SYNC_ARRAY,
    DMAEC_SYNC_BLOCK
  } dmaec_sync_t;

  // transfer request handed to the request engine
  typedef struct packed {
    logic [CH_IDX_W-1:0] channel;
    dmaec_sync_t sync_kind;
    logic dim_2d;
    logic [15:0] elem_count;
    logic [15:0] elem_stride;
    logic [16:0] blk_count;
  } dmaec_req_t;

endpackage

// File: rtl/dmaec_pick.sv
// fixed-order picker: lowest set bit of a channel vector
`timescale 1ns/10ps
module dmaec_pick (
  // candidates
  input wire logic [dmaec_pkg::NCH-1:0] cand_i,
  // result
  output logic found_o,
  output logic [dmaec_pkg::CH_IDX_W-1:0] idx_o
);
  import dmaec_pkg::*;

  // scan downward so the lowest index is the last to win
  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (cand_i[i]) begin
        found_o = 1'b1;
        idx_o = CH_IDX_W'(i);
      end
    end
  end

endmodule

// File: rtl/dmaec_top.sv
// event capture, enable and request front end with AHB-Lite registers
`timescale 1ns/10ps
// Function
// R1 - element transfer moves exactly one element, optionally gated per event
// R2 - frame is a group of elements, contiguous or staggered, synced or not
// R3 - array elements are contiguous; no element index spacing in 2D
// R4 - block is frames in 1D mode, arrays in 2D mode
// R5 - 1D frames per block equal frame count field plus one
// R6 - element count 1 to 65535; software must not program zero
// R7 - 1D sync moves one element or one whole frame per event
// R8 - 2D arrays per block equal frame count field plus one
// R9 - 2D sync moves one array or whole block per event
// R10 - each channel has one dedicated event; 16 or 64 channels
// R11 - every event is latched in pending register, enabled or not
// R12 - pending bits read-only, reset zero; narrow variant bits 31:16 reserved
// R13 - wide variant splits registers into low 0-31 and high 32-63
// R14 - writing 1 to an enable bit enables that event
// R15 - writing 0 to an enable bit stops its requests
// R16 - narrow variant events 8-11 enabled by chain enable register only
// R17 - narrow variant enable bits 8-11 read-only, writes ignored
// R18 - re-enabling with a pending bit processes that event
// R19 - pending bit clears when its transfer request is submitted
// R20 - writing 1 to clear register clears pending bit; 0 no effect
// R21 - writing 1 to set register sets pending bit even if disabled
// R22 - event inputs edge-detected; one occurrence sets pending once
// R23 - simultaneous enabled pending events forwarded one at a time, lowest first
module dmaec_top #(
  parameter bit WIDE_P = 1'b1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // peripheral events
  input wire logic [dmaec_pkg::NCH-1:0] evt_i,
  // transfer requests
  output logic req_valid_o,
  input wire logic req_ready_i,
  output dmaec_pkg::dmaec_req_t req_o
);
  import dmaec_pkg::*;

  function automatic logic [NCH-1:0] chan_mask(input bit wide);
    chan_mask = wide ? MASK_WIDE : MASK_NARROW;
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_addr);
    hit = (a[31:2] == ref_addr[31:2]);
  endfunction

  localparam logic [NCH-1:0] VMASK = chan_mask(WIDE_P);
  // bits software may never write in the enable register
  localparam logic [NCH-1:0] EN_RO = WIDE_P ? RST_VEC : CHAIN_ONLY_NARROW;

  // bus phase state
  logic dph_ff;
  logic wr_ff;
  logic [31:0] addr_ff;
  logic [31:0] hrdata_ff;
  // event state
  logic [NCH-1:0] pend_ff;
  logic [NCH-1:0] en_ff;
  logic [NCH-1:0] chain_ff;
  logic [NCH-1:0] pol_ff;
  logic [NCH-1:0] lvl_prev_ff;
  // geometry
  logic [15:0] elem_cnt_ff;
  logic dim_2d_ff;
  logic whole_ff;
  logic [15:0] frm_field_ff;
  logic [15:0] stride_ff;
  // request
  logic req_busy_ff;
  dmaec_req_t req_ff;

  logic take;
  logic wr_stb;
  logic rd_first;
  logic [31:0] rd_mux;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] edge_set;
  logic [NCH-1:0] sw_clr;
  logic [NCH-1:0] sw_set;
  logic [NCH-1:0] en_eff;
  logic [NCH-1:0] cand;
  logic [NCH-1:0] sub_clr;
  logic [NCH-1:0] nxt_pend;
  logic found;
  logic [CH_IDX_W-1:0] pick_idx;
  logic load;
  dmaec_req_t nxt_req;

  // ahb-lite: writes take no wait, reads one wait so data comes from a flop
  assign take = hsel_i & htrans_i[1] & hready_i;
  assign wr_stb = dph_ff & wr_ff;
  assign rd_first = dph_ff & ~wr_ff;
  assign hreadyout_o = ~rd_first;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dph_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= RST_WORD;
    end else begin
      dph_ff <= take;
      if (take) begin
        wr_ff <= hwrite_i;
        addr_ff <= haddr_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_ff <= RST_WORD;
    end else begin
      if (rd_first) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // read mux; unlisted and unbuilt registers read zero
  always_comb begin
    rd_mux = RST_WORD;
    if (hit(addr_ff, A_PEND_LO)) begin
      rd_mux = pend_ff[31:0]; // see R12
    end else if (hit(addr_ff, A_PEND_HI)) begin
      rd_mux = pend_ff[63:32]; // see R13
    end else if (hit(addr_ff, A_EN_LO)) begin
      rd_mux = en_ff[31:0];
    end else if (hit(addr_ff, A_EN_HI)) begin
      rd_mux = en_ff[63:32];
    end else if (hit(addr_ff, A_CHAIN_LO)) begin
      rd_mux = chain_ff[31:0];
    end else if (hit(addr_ff, A_CHAIN_HI)) begin
      rd_mux = chain_ff[63:32];
    end else if (hit(addr_ff, A_POL_LO)) begin
      rd_mux = pol_ff[31:0];
    end else if (hit(addr_ff, A_POL_HI)) begin
      rd_mux = pol_ff[63:32];
    end else if (hit(addr_ff, A_GEO_CNT)) begin
      rd_mux[GEO_ELEM_LSB +: 16] = elem_cnt_ff;
      rd_mux[GEO_2D_BIT] = dim_2d_ff;
      rd_mux[GEO_WHOLE_BIT] = whole_ff;
      rd_mux[GEO_ERR_BIT] = (elem_cnt_ff == 16'h0000); // see R6
    end else if (hit(addr_ff, A_GEO_IDX)) begin
      rd_mux[GEO_FRM_LSB +: 16] = frm_field_ff;
      rd_mux[GEO_STRIDE_LSB +: 16] = stride_ff;
    end
  end

  // clear and set strobes, one word per half; high half absent when narrow
  assign sw_clr = {(wr_stb & hit(addr_ff, A_CLR_HI)) ? hwdata_i : RST_WORD,
                   (wr_stb & hit(addr_ff, A_CLR_LO)) ? hwdata_i : RST_WORD} & VMASK; // see R20
  assign sw_set = {(wr_stb & hit(addr_ff, A_SET_HI)) ? hwdata_i : RST_WORD,
                   (wr_stb & hit(addr_ff, A_SET_LO)) ? hwdata_i : RST_WORD} & VMASK; // see R21

  // enable, chain and polarity words
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      en_ff <= RST_VEC;
    end else begin
      if (wr_stb & hit(addr_ff, A_EN_LO)) begin
        en_ff[31:0] <= hwdata_i & VMASK[31:0] & ~EN_RO[31:0]; // see R14, R15, R17
      end
      if (wr_stb & hit(addr_ff, A_EN_HI)) begin
        en_ff[63:32] <= hwdata_i & VMASK[63:32]; // see R13
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      chain_ff <= RST_VEC;
    end else begin
      if (wr_stb & hit(addr_ff, A_CHAIN_LO)) begin
        chain_ff[31:0] <= hwdata_i & VMASK[31:0];
      end
      if (wr_stb & hit(addr_ff, A_CHAIN_HI)) begin
        chain_ff[63:32] <= hwdata_i & VMASK[63:32];
      end
    end
  end

  // polarity select exists only on the wide variant
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pol_ff <= RST_VEC;
    end else if (WIDE_P) begin
      if (wr_stb & hit(addr_ff, A_POL_LO)) begin
        pol_ff[31:0] <= hwdata_i;
      end
      if (wr_stb & hit(addr_ff, A_POL_HI)) begin
        pol_ff[63:32] <= hwdata_i;
      end
    end
  end

  // geometry words
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      elem_cnt_ff <= RST_ELEM_CNT;
      dim_2d_ff <= 1'b0;
      whole_ff <= 1'b0;
      frm_field_ff <= RST_FIELD;
      stride_ff <= RST_FIELD;
    end else begin
      if (wr_stb & hit(addr_ff, A_GEO_CNT)) begin
        elem_cnt_ff <= hwdata_i[GEO_ELEM_LSB +: 16];
        dim_2d_ff <= hwdata_i[GEO_2D_BIT];
        whole_ff <= hwdata_i[GEO_WHOLE_BIT];
      end
      if (wr_stb & hit(addr_ff, A_GEO_IDX)) begin
        frm_field_ff <= hwdata_i[GEO_FRM_LSB +: 16];
        stride_ff <= hwdata_i[GEO_STRIDE_LSB +: 16];
      end
    end
  end

  // edge detect; a polarity change can itself look like an edge
  assign lvl = evt_i ^ pol_ff;
  assign edge_set = lvl & ~lvl_prev_ff & VMASK; // see R22, R10

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_prev_ff <= RST_VEC;
    end else begin
      lvl_prev_ff <= lvl;
    end
  end

  // chain-only channels on the narrow variant follow the chain enable word
  assign en_eff = (en_ff | (chain_ff & EN_RO)) & VMASK; // see R16
  assign cand = pend_ff & en_eff; // see R15, R18

  dmaec_pick u_pick (
    .cand_i (cand),
    .found_o (found),
    .idx_o (pick_idx)
  ); // see R23

  assign load = found & (~req_busy_ff | req_ready_i);
  assign sub_clr = load ? (RST_VEC | (64'h1 << pick_idx)) : RST_VEC;

  // sets win over both kinds of clear so no event is lost
  assign nxt_pend = ((pend_ff & ~sw_clr & ~sub_clr) | edge_set | sw_set) & VMASK; // see R11, R19

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pend_ff <= RST_VEC; // see R12
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // request contents: geometry of the block seen per event
  always_comb begin
    nxt_req.channel = pick_idx;
    nxt_req.dim_2d = dim_2d_ff; // see R4
    nxt_req.elem_count = elem_cnt_ff; // see R1, R2
    nxt_req.elem_stride = dim_2d_ff ? RST_FIELD : stride_ff; // see R3
    nxt_req.blk_count = {1'b0, frm_field_ff} + 17'h00001; // see R5, R8
    if (dim_2d_ff) begin
      nxt_req.sync_kind = whole_ff ? DMAEC_SYNC_BLOCK : DMAEC_SYNC_ARRAY; // see R9
    end else begin
      nxt_req.sync_kind = whole_ff ? DMAEC_SYNC_FRAME : DMAEC_SYNC_ELEMENT; // see R7
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_busy_ff <= 1'b0;
      req_ff <= '0;
    end else begin
      req_busy_ff <= load | (req_busy_ff & ~req_ready_i);
      if (load) begin
        req_ff <= nxt_req;
      end
    end
  end

  assign req_valid_o = req_busy_ff;
  assign req_o = req_ff;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_edge_latched;
    (|edge_set) |=> ((pend_ff & $past(edge_set)) == $past(edge_set));
  endproperty
  a_edge_latched: assert property (p_edge_latched) else $error("edge not latched"); // see R11

  property p_submit_clears;
    load && !(edge_set[pick_idx] || sw_set[pick_idx]) |=> !pend_ff[$past(pick_idx)];
  endproperty
  a_submit_clears: assert property (p_submit_clears) else $error("pending kept"); // see R19

  property p_only_enabled;
    load |-> en_eff[pick_idx] && pend_ff[pick_idx];
  endproperty
  a_only_enabled: assert property (p_only_enabled) else $error("disabled event sent"); // see R15

  property p_lowest_first;
    load |-> ((cand & ((64'h1 << pick_idx) - 64'h1)) == RST_VEC);
  endproperty
  a_lowest_first: assert property (p_lowest_first) else $error("order broken"); // see R23

  property p_narrow_ro;
    !WIDE_P |-> (en_ff[11:8] == 4'h0) && (pend_ff[63:16] == 48'h0);
  endproperty
  a_narrow_ro: assert property (p_narrow_ro) else $error("narrow bits set"); // see R17

  property p_sw_clear;
    (|sw_clr) |=> ((pend_ff & $past(sw_clr) & ~$past(edge_set | sw_set)) == RST_VEC);
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("clear ignored"); // see R20

  property p_sw_set;
    (|sw_set) |=> ((pend_ff & $past(sw_set)) == $past(sw_set));
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("set ignored"); // see R21

  property p_blk_count;
    load |=> req_ff.blk_count == ({1'b0, $past(frm_field_ff)} + 17'h00001);
  endproperty
  a_blk_count: assert property (p_blk_count) else $error("block count wrong"); // see R5

  property p_no_stride_2d;
    req_valid_o && req_o.dim_2d |-> req_o.elem_stride == RST_FIELD;
  endproperty
  a_no_stride_2d: assert property (p_no_stride_2d) else $error("stride in 2d"); // see R3

  property p_pending_served;
    (|cand) && !req_busy_ff |=> req_valid_o;
  endproperty
  a_pending_served: assert property (p_pending_served) else $error("pending not served"); // see R18

  // a level held through a clear must not set the bit again
  property p_single_edge;
    (sw_clr & lvl & lvl_prev_ff & ~sw_set) != RST_VEC |=>
      (pend_ff & $past(sw_clr & lvl & lvl_prev_ff & ~sw_set)) == RST_VEC;
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("repeat edge"); // see R22

  c_request: cover property (req_valid_o && req_ready_i);
  c_stall: cover property (req_valid_o && !req_ready_i ##1 req_valid_o && req_ready_i);
  c_two_pending: cover property ($countones(cand) > 1);
  c_set_clear_clash: cover property ((sw_clr & edge_set) != RST_VEC);

endmodule

// File: bench/dmaec_engine_model.sv
// behavioural request engine on the far side of the front end
`timescale 1ns/10ps
module dmaec_engine_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // request handshake
  input wire logic req_valid_i,
  input wire dmaec_pkg::dmaec_req_t req_i,
  input wire logic stall_i,
  output logic req_ready_o
);
  import dmaec_pkg::*;
  // accepted requests, oldest first; the bench pops them
  dmaec_req_t got[$];
  // stall holds ready low so the request must keep standing
  assign req_ready_o = ~stall_i;
  always @(posedge clk_sys_i) begin
    if (!rst_i && req_valid_i && req_ready_o) begin
      got.push_back(req_i);
    end
  end
endmodule

// File: bench/dmaec_top_test.sv
// testbench for the event capture front end
`timescale 1ns/10ps
module dmaec_top_test;
  import dmaec_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic nar = 1'b0;
  logic hready;
  logic hready_w;
  logic hready_n;
  logic hresp;
  logic hresp_w;
  logic hresp_n;
  logic [31:0] hrdata;
  logic [31:0] hrdata_w;
  logic [31:0] hrdata_n;
  logic req_valid_n;
  logic req_ready_n;
  dmaec_req_t req_n;
  logic [NCH-1:0] evt = 64'h0;
  logic req_valid;
  logic req_ready;
  logic stall = 1'b0;
  dmaec_req_t req;
  int n_errors = 0;
  int tests_run = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  // one bus, two slaves: nar picks the narrow variant between transfers
  assign hready = nar ? hready_n : hready_w;
  assign hresp = nar ? hresp_n : hresp_w;
  assign hrdata = nar ? hrdata_n : hrdata_w;

  dmaec_top #(.WIDE_P(1'b1)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel & ~nar),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready_w), .hresp_o(hresp_w),
    .hrdata_o(hrdata_w), .evt_i(evt), .req_valid_o(req_valid), .req_ready_i(req_ready),
    .req_o(req));

  dmaec_top #(.WIDE_P(1'b0)) DUT_NARROW (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .hsel_i(hsel & nar), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready_n),
    .hresp_o(hresp_n), .hrdata_o(hrdata_n), .evt_i(evt), .req_valid_o(req_valid_n),
    .req_ready_i(req_ready_n), .req_o(req_n));

  dmaec_engine_model eng_n (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_n),
    .req_i(req_n), .stall_i(1'b0), .req_ready_o(req_ready_n));

  dmaec_engine_model eng (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid),
    .req_i(req), .stall_i(stall), .req_ready_o(req_ready));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hready is taken from the half cycle before the edge, so no race with the edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic ok;
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(negedge clk_sys_i);
      ok = hready;
      @(posedge clk_sys_i);
    end while (ok !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge clk_sys_i);
      ok = hready;
      r = hrdata;
      @(posedge clk_sys_i);
    end while (ok !== 1'b1);
    chk({63'h0, hresp}, 64'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk({32'h0, r}, {32'h0, e});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic exp_req(input logic [5:0] ch, input dmaec_sync_t k, input logic d2,
                         input logic [15:0] el, input logic [15:0] st, input logic [16:0] blk);
    dmaec_req_t q;
    dmaec_req_t e;
    for (int i = 0; i < 40 && (nar ? eng_n.got.size() : eng.got.size()) == 0; i++)
      @(posedge clk_sys_i);
    if (nar && eng_n.got.size() > 0) begin
      q = eng_n.got.pop_front();
    end else if (!nar && eng.got.size() > 0) begin
      q = eng.got.pop_front();
    end else begin
      q = '1;
    end
    e = '{ch, k, d2, el, st, blk};
    chk(64'(q), 64'(e));
  endtask

  task automatic t_reset;
    rd_chk(A_PEND_LO, 32'h0);
    rd_chk(A_PEND_HI, 32'h0);
    rd_chk(A_EN_LO, 32'h0);
    rd_chk(A_GEO_CNT, 32'h1);
    wr(A_PEND_LO, 32'hffffffff);
    rd_chk(A_PEND_LO, 32'h0);
    wr(32'h01a0ff00, 32'hffffffff);
    rd_chk(32'h01a0ff00, 32'h0);
    wr(A_POL_HI, 32'h1);
    rd_chk(A_POL_HI, 32'h1);
    rd_chk(A_PEND_HI, 32'h1);
    wr(A_POL_HI, 32'h0);
    wr(A_CLR_HI, 32'h1);
    rd_chk(A_PEND_HI, 32'h0);
  endtask

  // narrow variant: reserved upper half and chain-only channels 8 to 11
  task automatic t_narrow;
    nar <= 1'b1;
    wr(A_EN_LO, 32'hffffffff);
    rd_chk(A_EN_LO, 32'h0000f0ff);
    wr(A_SET_LO, 32'h00010900);
    wr(A_SET_HI, 32'hffffffff);
    rd_chk(A_PEND_LO, 32'h00000900);
    rd_chk(A_PEND_HI, 32'h0);
    chk(eng_n.got.size(), 0);
    wr(A_CHAIN_LO, 32'h00000800);
    exp_req(6'd11, DMAEC_SYNC_ELEMENT, 1'b0, 16'h1, 16'h0, 17'h1);
    rd_chk(A_PEND_LO, 32'h00000100);
    wr(A_CLR_LO, 32'h00000100);
    wr(A_EN_LO, 32'h0);
    nar <= 1'b0;
  endtask

  // a long event level while disabled, cleared, then re-armed
  task automatic t_held;
    evt[3] <= 1'b1;
    cycles(6);
    rd_chk(A_PEND_LO, 32'h8);
    chk(eng.got.size(), 0);
    wr(A_CLR_LO, 32'h8);
    rd_chk(A_PEND_LO, 32'h0);
    wr(A_EN_LO, 32'h8);
    cycles(6);
    chk(eng.got.size(), 0);
    evt[3] <= 1'b0;
    cycles(1);
    evt[3] <= 1'b1;
    exp_req(6'd3, DMAEC_SYNC_ELEMENT, 1'b0, 16'h1, 16'h0, 17'h1);
    rd_chk(A_PEND_LO, 32'h0);
    evt[3] <= 1'b0;
  endtask

  // software set while disabled, then enabled against a stalled engine
  task automatic t_order;
    stall <= 1'b1;
    wr(A_EN_LO, 32'h0);
    wr(A_SET_LO, 32'h24);
    wr(A_SET_HI, 32'h100);
    rd_chk(A_PEND_LO, 32'h24);
    rd_chk(A_PEND_HI, 32'h100);
    wr(A_EN_LO, 32'h24);
    wr(A_EN_HI, 32'h100);
    cycles(4);
    chk({57'h0, req_valid, req.channel}, {57'h1, 6'd2});
    stall <= 1'b0;
    exp_req(6'd2, DMAEC_SYNC_ELEMENT, 1'b0, 16'h1, 16'h0, 17'h1);
    exp_req(6'd5, DMAEC_SYNC_ELEMENT, 1'b0, 16'h1, 16'h0, 17'h1);
    exp_req(6'd40, DMAEC_SYNC_ELEMENT, 1'b0, 16'h1, 16'h0, 17'h1);
    rd_chk(A_PEND_HI, 32'h0);
  endtask

  task automatic t_disable;
    wr(A_EN_LO, 32'h0);
    wr(A_SET_LO, 32'h80);
    cycles(4);
    chk(eng.got.size(), 0);
    wr(A_CLR_LO, 32'h0);
    rd_chk(A_PEND_LO, 32'h80);
    wr(A_CLR_LO, 32'h80);
    rd_chk(A_PEND_LO, 32'h0);
  endtask

  // every mode and granularity, last one at the full frame count
  task automatic t_geo;
    logic [15:0] fr;
    wr(A_EN_LO, 32'h2);
    for (int k = 0; k < 4; k++) begin
      fr = (k == 3) ? 16'hffff : 16'(k);
      wr(A_GEO_CNT, {14'h0, k[0], k[1], 16'(7 + k)});
      wr(A_GEO_IDX, {16'h0030, fr});
      wr(A_SET_LO, 32'h2);
      exp_req(6'd1, dmaec_sync_t'(k[1:0]), k[1], 16'(7 + k), k[1] ? 16'h0 : 16'h0030,
              17'(fr) + 17'h1);
    end
    wr(A_GEO_CNT, 32'h0);
    rd_chk(A_GEO_CNT, 32'h80000000);
  endtask

  task automatic results;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    cycles(8);
    rst_i <= 1'b0;
    t_reset();
    t_narrow();
    t_held();
    t_order();
    t_disable();
    t_geo();
    results();
  end

  // the tests need about 250 cycles; this allows far more
  initial begin
    #1000000;
    n_errors++;
    results();
  end
endmodule
